/* File: rtl/nfbi_defines.vh */
/*
 Constants for the NOR flash bus interface: command codes, sequencer states,
 status reset value, field positions and timing.
 Assumes inclusion by bare name from the design file.
*/
`ifndef NFBI_DEFINES_VH
`define NFBI_DEFINES_VH

`define NFBI_CMD_READ_ARRAY   8'hFF
`define NFBI_CMD_READ_STATUS  8'h70
`define NFBI_CMD_READ_ID      8'h90
`define NFBI_CMD_READ_CFI     8'h98
`define NFBI_CMD_PROGRAM      8'h40
`define NFBI_CMD_ALT_PROGRAM  8'h10
`define NFBI_CMD_BUF_PROGRAM  8'hE8
`define NFBI_CMD_ERASE        8'h20
`define NFBI_CMD_CONFIRM      8'hD0

`define NFBI_STATUS_RESET     8'h80
`define NFBI_STATUS_READY_BIT 7
`define NFBI_WAIT_POL_BIT     10
`define NFBI_RCR_RESET        16'hBFCF
`define NFBI_RCR_ASYNC_BIT    15

`define NFBI_ST_IDLE          3'b001
`define NFBI_ST_SETUP         3'b010
`define NFBI_ST_BUSY          3'b100

`define NFBI_OP_TIME_NS       1000
`define NFBI_CLK_PERIOD_NS    10
`define NFBI_WAIT_CYCLES      2
`define NFBI_CFI_WIDTH        8

`endif

/* File: rtl/nfbi_bus_if.v */
/*
 Host-bus front end of a 16-bit parallel NOR flash: bus state decode,
 write latching into the command interface and read mode selection.
 Assumes all pins synchronous to mclk; the array itself sits outside,
 reached by array_addr/array_rdata, and id/cfi data come in as ports.
*/
`timescale 1ns/1ns
`include "nfbi_defines.vh"

module nfbi_bus_if #(
  parameter ADDR_W    = 26,
  parameter BLOCK_W   = 9,
  parameter OP_CYCLES = (`NFBI_OP_TIME_NS + `NFBI_CLK_PERIOD_NS - 1) / `NFBI_CLK_PERIOD_NS
) (
  input  wire                mclk,
  input  wire                rst,
  input  wire                ce,
  input  wire                reset_n,
  input  wire                chip_sel_n,
  input  wire                out_en_n,
  input  wire                write_en_n,
  input  wire                address_valid_n,
  input  wire                flash_clk,
  input  wire [ADDR_W-1:0]   addr,
  input  wire [15:0]         dq_in,
  input  wire [15:0]         array_rdata,
  input  wire [15:0]         id_rdata,
  input  wire [7:0]          cfi_rdata,
  input  wire [15:0]         rcr_value,
  output reg  [15:0]         dq_out,
  output reg                 dq_oe,
  output reg                 wait_out,
  output reg                 wait_oe,
  output reg  [ADDR_W-1:0]   array_addr,
  output reg  [BLOCK_W-1:0]  block_sel,
  output reg                 standby,
  output reg                 op_busy,
  output reg                 op_invalid,
  output reg  [7:0]          status,
  output reg  [1:0]          read_mode
);

  // Read modes select what a read cycle puts on the data bus
  localparam MODE_ARRAY  = 2'h0;
  localparam MODE_STATUS = 2'h1;
  localparam MODE_ID     = 2'h2;
  localparam MODE_CFI    = 2'h3;

  // Command sequencer states, one-hot
  localparam ST_IDLE  = 3'h1;
  localparam ST_SETUP = 3'h2;
  localparam ST_BUSY  = 3'h4;

  reg [2:0]        state;
  reg [2:0]        next_state;
  reg [31:0]       op_count;
  reg              wr_cycle_d;
  reg              clk_d;
  reg              addr_valid_d;
  reg [ADDR_W-1:0] wr_addr;
  reg [15:0]       wr_data;
  reg              sync_pending;
  reg [1:0]        wait_cnt;
  reg [15:0]       rd_sel;
  reg [1:0]        next_read_mode;
  reg              next_busy;

  wire device_on   = reset_n;
  wire wr_cycle    = device_on && !chip_sel_n && !write_en_n && out_en_n;
  wire wr_done     = wr_cycle_d && !wr_cycle;
  wire [7:0] cmd   = wr_data[7:0];
  wire rd_cycle    = device_on && !chip_sel_n && !out_en_n && write_en_n;
  wire sync_mode   = !rcr_value[`NFBI_RCR_ASYNC_BIT];
  wire clk_rise    = flash_clk && !clk_d;
  wire adv_rise    = address_valid_n && !addr_valid_d;
  wire wait_level  = rcr_value[`NFBI_WAIT_POL_BIT];
  wire addr_ph     = !address_valid_n && !chip_sel_n;
  wire setup_cmd   = (cmd == `NFBI_CMD_PROGRAM) || (cmd == `NFBI_CMD_ALT_PROGRAM) || (cmd == `NFBI_CMD_ERASE);
  wire op_start    = (state == ST_SETUP) && wr_done;
  wire op_end      = (state == ST_BUSY) && (op_count == 32'h0000_0000);
  wire sync_wait   = rd_cycle && sync_mode && (wait_cnt != `NFBI_WAIT_CYCLES);

  // Write capture: first deassertion of either strobe ends the cycle
  always @(posedge mclk) begin
    if (rst) begin
      wr_cycle_d <= 1'b0;
      wr_addr    <= {ADDR_W{1'b0}};
      wr_data    <= 16'h0000;
    end else if (ce) begin
      wr_cycle_d <= wr_cycle;
      if (wr_cycle) begin
        wr_addr <= addr;
        wr_data <= dq_in;
      end
    end
  end

  // Address latch: open while strobe low; in sync mode closes at strobe rise or first clock
  always @(posedge mclk) begin
    if (rst) begin
      array_addr   <= {ADDR_W{1'b0}};
      block_sel    <= {BLOCK_W{1'b0}};
      clk_d        <= 1'b0;
      addr_valid_d <= 1'b1;
      sync_pending <= 1'b0;
    end else if (ce) begin
      clk_d        <= flash_clk;
      addr_valid_d <= address_valid_n;
      if (addr_ph && (!sync_mode || !sync_pending)) begin
        array_addr <= addr;
        block_sel  <= addr[ADDR_W-1:ADDR_W-BLOCK_W];
      end
      if (sync_mode && addr_ph && clk_rise) begin
        sync_pending <= 1'b1;
      end else if (address_valid_n || adv_rise) begin
        sync_pending <= 1'b0;
      end
    end
  end

  // Command interface and internal operation sequencer
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (wr_done && setup_cmd) begin
          next_state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        // Any second write starts the operation; its data is not checked
        if (wr_done) begin
          next_state = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (op_end) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Busy one cycle ahead, so standby never sees a stale busy flag
  always @* begin
    next_busy = op_busy;
    if (!reset_n) begin
      next_busy = 1'b0;
    end else if (op_start) begin
      next_busy = 1'b1;
    end else if (op_end) begin
      next_busy = 1'b0;
    end
  end

  // Read mode decode; only status reads are honoured while busy
  always @* begin
    next_read_mode = read_mode;
    if (!reset_n) begin
      next_read_mode = MODE_ARRAY;
    end else if (op_start) begin
      next_read_mode = MODE_STATUS;
    end else if (wr_done && state == ST_IDLE) begin
      if (cmd == `NFBI_CMD_READ_ARRAY) begin
        next_read_mode = MODE_ARRAY;
      end else if (cmd == `NFBI_CMD_READ_STATUS) begin
        next_read_mode = MODE_STATUS;
      end else if (cmd == `NFBI_CMD_READ_ID) begin
        next_read_mode = MODE_ID;
      end else if (cmd == `NFBI_CMD_READ_CFI) begin
        next_read_mode = MODE_CFI;
      end else if (setup_cmd) begin
        next_read_mode = MODE_STATUS;
      end
    end else if (wr_done && state == ST_BUSY && cmd == `NFBI_CMD_READ_STATUS) begin
      next_read_mode = MODE_STATUS;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      state      <= ST_IDLE;
      op_count   <= 32'h0000_0000;
      op_busy    <= 1'b0;
      op_invalid <= 1'b0;
      status     <= `NFBI_STATUS_RESET;
      read_mode  <= MODE_ARRAY;
    end else if (ce) begin
      op_busy   <= next_busy;
      read_mode <= next_read_mode;
      if (!reset_n) begin
        // Pin reset aborts a running operation and marks its target bad
        state    <= ST_IDLE;
        op_count <= 32'h0000_0000;
        status   <= `NFBI_STATUS_RESET;
        if (op_busy) begin
          op_invalid <= 1'b1;
        end
      end else begin
        state <= next_state;
        // Busy runs down regardless of chip select
        if (state == ST_BUSY && op_count != 32'h0000_0000) begin
          op_count <= op_count - 32'h0000_0001;
        end
        if (op_start) begin
          op_count   <= OP_CYCLES - 1;
          op_invalid <= 1'b0;
          status[`NFBI_STATUS_READY_BIT] <= 1'b0;
        end else if (op_end) begin
          status[`NFBI_STATUS_READY_BIT] <= 1'b1;
        end
      end
    end
  end

  // Status and CFI query data occupy the low byte only; ID data uses all 16 bits
  always @* begin
    rd_sel = array_rdata;
    case (read_mode)
      MODE_ARRAY: begin
        rd_sel = array_rdata;
      end
      MODE_STATUS: begin
        rd_sel = {8'h00, status};
      end
      MODE_ID: begin
        rd_sel = id_rdata;
      end
      MODE_CFI: begin
        rd_sel = {8'h00, cfi_rdata};
      end
      default: begin
        rd_sel = array_rdata;
      end
    endcase
  end

  // Data drivers share the read qualifier with the wait pin
  always @(posedge mclk) begin
    if (rst) begin
      dq_out <= 16'h0000;
      dq_oe  <= 1'b0;
    end else if (ce) begin
      dq_oe  <= rd_cycle;
      dq_out <= rd_cycle ? rd_sel : 16'h0000;
    end
  end

  // Standby follows the next busy value so it never overlaps an operation
  always @(posedge mclk) begin
    if (rst) begin
      standby <= 1'b0;
    end else if (ce) begin
      standby <= chip_sel_n && !next_busy && reset_n;
    end
  end

  // Wait counts clock rises once the address phase has closed
  always @(posedge mclk) begin
    if (rst) begin
      wait_out <= 1'b0;
      wait_oe  <= 1'b0;
      wait_cnt <= 2'h0;
    end else if (ce) begin
      wait_oe <= rd_cycle;
      if (!rd_cycle || addr_ph) begin
        wait_cnt <= 2'h0;
      end else if (sync_mode && clk_rise && wait_cnt != `NFBI_WAIT_CYCLES) begin
        wait_cnt <= wait_cnt + 2'h1;
      end
      if (sync_wait) begin
        wait_out <= wait_level;
      end else begin
        wait_out <= !wait_level;
      end
    end
  end

endmodule

/* File: tb/nfbi_host_model.sv */
/*
 Host side of the flash bus: drives the control pins, address and write data.
 Assumes mclk from the bench and one task in flight at a time.
*/
`timescale 1ns/1ns
module nfbi_host_model (
  input  wire        mclk,
  input  wire [15:0] dq_out,
  input  wire        wait_out,
  output reg         reset_n = 1'b0,
  output reg         chip_sel_n = 1'b1,
  output reg         out_en_n = 1'b1,
  output reg         write_en_n = 1'b1,
  output reg         address_valid_n = 1'b1,
  output reg         flash_clk = 1'b0,
  output reg  [25:0] addr = 26'h000_0000,
  output reg  [15:0] dq_in = 16'h0000
);
  task automatic wr(input logic [7:0] c);
    // Single die only, so a setup pair never straddles two dies
    @(posedge mclk) #1;
    {chip_sel_n, write_en_n, address_valid_n} = 3'b000;
    dq_in = {8'h00, c};
    repeat (2) @(posedge mclk);
    #1 {chip_sel_n, write_en_n, address_valid_n} = 3'b111;
    // Released bus must not keep the last value
    dq_in = ~dq_in;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  task automatic rd(input logic [25:0] a, output logic [15:0] d, output logic w0, output logic w1);
    @(posedge mclk) #1;
    {chip_sel_n, out_en_n, address_valid_n} = 3'b000;
    addr = a;
    // Latch closes after one edge; its data appears one edge later
    @(posedge mclk) #1 address_valid_n = 1'b1;
    @(posedge mclk) #1 d = dq_out;
    w0 = wait_out;
    // Clock runs only inside the read
    repeat (8) @(posedge mclk) #1 flash_clk = ~flash_clk;
    w1 = wait_out;
    {chip_sel_n, out_en_n} = 2'b11;
    @(posedge mclk) #1;
  endtask
  task automatic hw_reset;
    @(posedge mclk) #1 reset_n = 1'b0;
    repeat (2) @(posedge mclk);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
  endtask
endmodule

/* File: tb/nfbi_bus_if_props.sv */
/*
 Pin-level checks of the flash bus front end.
 Assumes binding into nfbi_bus_if and the read timing of one cycle.
*/
`timescale 1ns/1ns
module nfbi_bus_if_props #(
  parameter ADDR_W  = 26,
  parameter BLOCK_W = 9
) (
  input wire               mclk, rst, ce, reset_n, chip_sel_n, out_en_n, write_en_n, address_valid_n,
  input wire [ADDR_W-1:0]  addr, array_addr,
  input wire [15:0]        rcr_value, dq_out,
  input wire               dq_oe, wait_out, wait_oe, standby, op_busy,
  input wire [BLOCK_W-1:0] block_sel,
  input wire [7:0]         status,
  input wire [1:0]         read_mode
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire rd_on = ce & reset_n & ~chip_sel_n & ~out_en_n & write_en_n;
  // Sync mode closes the latch at the first clock rise, so only async phases are checked
  wire open_lat = ce & reset_n & ~address_valid_n & ~chip_sel_n & rcr_value[15];
  wire [BLOCK_W-1:0] blk = addr[ADDR_W-1 -: BLOCK_W];
  a_read_drive: assert property (rd_on |=> dq_oe && wait_oe) else $error("read not driven");
  a_oe_float: assert property (ce && out_en_n |=> !dq_oe && !wait_oe) else $error("oe high drives");
  a_desel_float: assert property (ce && chip_sel_n |=> !dq_oe) else $error("deselect drives");
  a_reset_float: assert property (ce && !reset_n |=> !dq_oe && !wait_oe) else $error("reset drives");
  a_reset_mode: assert property (ce && !reset_n |=> status == 8'h80 && read_mode == 2'h0)
    else $error("reset state wrong");
  a_latch_open: assert property (open_lat |=> array_addr == $past(addr)) else $error("latch closed");
  a_block_decode: assert property (open_lat |=> block_sel == $past(blk)) else $error("block wrong");
  a_byte_modes: assert property (dq_oe && read_mode[0] |-> dq_out[15:8] == 8'h00)
    else $error("upper byte set");
  a_async_wait: assert property (wait_oe && rcr_value[15] |-> wait_out == !rcr_value[10])
    else $error("async wait asserted");
  a_busy_awake: assert property (op_busy |-> !standby) else $error("standby while busy");
  c_id_read: cover property (rd_on && read_mode == 2'd2);
  c_busy_desel: cover property (op_busy && chip_sel_n);
  c_sync_wait: cover property (wait_oe && !rcr_value[15]);
endmodule
bind nfbi_bus_if nfbi_bus_if_props #(.ADDR_W(ADDR_W), .BLOCK_W(BLOCK_W)) props (.*);

/* File: tb/tb.sv */
/*
 Self-checking bench of the flash bus front end with a host model.
 Assumes the array answers array_addr at once with a fixed pattern.
*/
`timescale 1ns/1ns
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin miscompares++; $display("BAD %s exp %h got %h", n, e, s); end end
module tb;
  reg         mclk = 1'b0;
  reg         rst = 1'b1;
  reg  [15:0] rcr_value = 16'hBFCF;
  reg         ce = 1'b1;
  reg  [15:0] id_rdata = 16'h3C5A;
  reg  [7:0]  cfi_rdata = 8'h96;
  int         miscompares = 0;
  int         comparisons = 0;
  wire        reset_n, chip_sel_n, out_en_n, write_en_n, address_valid_n, flash_clk;
  wire        dq_oe, wait_out, wait_oe, standby, op_busy, op_invalid;
  wire [25:0] addr, array_addr;
  wire [15:0] dq_in, dq_out, array_rdata;
  wire [8:0]  block_sel;
  wire [7:0]  status;
  wire [1:0]  read_mode;
  reg  [15:0] d;
  reg         w0, w1;
  assign array_rdata = array_addr[15:0] ^ 16'hA5A5;
  always #5 mclk = ~mclk;
  nfbi_host_model host (.mclk(mclk), .dq_out(dq_out), .wait_out(wait_out), .reset_n(reset_n),
    .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .write_en_n(write_en_n),
    .address_valid_n(address_valid_n), .flash_clk(flash_clk), .addr(addr), .dq_in(dq_in));
  nfbi_bus_if #(.OP_CYCLES(20)) dut (.mclk(mclk), .rst(rst), .ce(ce), .reset_n(reset_n),
    .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .write_en_n(write_en_n),
    .address_valid_n(address_valid_n), .flash_clk(flash_clk), .addr(addr), .dq_in(dq_in),
    .array_rdata(array_rdata), .id_rdata(id_rdata), .cfi_rdata(cfi_rdata), .rcr_value(rcr_value),
    .dq_out(dq_out), .dq_oe(dq_oe), .wait_out(wait_out), .wait_oe(wait_oe), .array_addr(array_addr),
    .block_sel(block_sel), .standby(standby), .op_busy(op_busy), .op_invalid(op_invalid),
    .status(status), .read_mode(read_mode));
  task final_report;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task t_defaults;
    `CHK("status", 8'h80, status)
    host.rd(26'h3FE_1234, d, w0, w1);
    `CHK("array", 16'h1234 ^ 16'hA5A5, d)
    `CHK("block", 9'h1FF, block_sel)
    `CHK("wait", 1'b0, w0)
    $display("t_defaults done");
  endtask
  task t_modes;
    logic [7:0] c;
    logic [15:0] e;
    for (int i = 0; i < 4; i++) begin
      c = (i == 0) ? 8'h70 : (i == 1) ? 8'h90 : (i == 2) ? 8'h98 : 8'hFF;
      e = (i == 0) ? 16'h0080 : (i == 1) ? 16'h3C5A : (i == 2) ? 16'h0096 : 16'h0055 ^ 16'hA5A5;
      host.wr(c);
      host.rd(26'h000_0055, d, w0, w1);
      `CHK("mode", (i == 3) ? 2'd0 : 2'(i + 1), read_mode)
      `CHK("data", e, d)
    end
    $display("t_modes done");
  endtask
  task t_program;
    int i;
    host.wr(8'h40);
    host.wr(8'h12);
    `CHK("busy", 1'b1, op_busy)
    `CHK("awake", 1'b0, standby)
    `CHK("ready", 1'b0, status[7])
    // Busy device must ignore a mode change other than status
    host.wr(8'hFF);
    `CHK("mode", 2'd1, read_mode)
    for (i = 0; i < 100 && op_busy !== 1'b0; i++) begin
      @(posedge mclk) #1;
    end
    `CHK("done", 1'b0, op_busy)
    if (op_busy !== 1'b0) final_report;
    `CHK("status", 8'h80, status)
    `CHK("standby", 1'b1, standby)
    $display("t_program done");
  endtask
  task t_abort;
    host.wr(8'h20);
    host.wr(8'hD0);
    host.hw_reset;
    `CHK("invalid", 1'b1, op_invalid)
    `CHK("busy", 1'b0, op_busy)
    `CHK("mode", 2'd0, read_mode)
    `CHK("status", 8'h80, status)
    $display("t_abort done");
  endtask
  task t_sync;
    rcr_value = 16'h0400;
    host.rd(26'h000_0077, d, w0, w1);
    `CHK("wait_busy", 1'b1, w0)
    `CHK("wait_ready", 1'b0, w1)
    rcr_value = 16'h8000;
    host.rd(26'h000_0077, d, w0, w1);
    `CHK("wait_async", 1'b1, w1)
    $display("t_sync done");
  endtask
  task t_freeze;
    // Clock enable low must hide a whole command from the device
    ce = 1'b0;
    host.wr(8'h90);
    `CHK("frozen_mode", 2'h0, read_mode)
    ce = 1'b1;
    host.wr(8'h90);
    id_rdata = 16'hC3A5;
    host.rd(26'h000_0011, d, w0, w1);
    `CHK("id_data", 16'hC3A5, d)
    cfi_rdata = 8'h69;
    host.wr(8'h98);
    host.rd(26'h000_0011, d, w0, w1);
    `CHK("cfi_data", 16'h0069, d)
    $display("t_freeze done");
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    #1 rst = 1'b0;
    host.hw_reset;
    t_defaults;
    t_modes;
    t_program;
    t_abort;
    t_sync;
    t_freeze;
    final_report;
  end
endmodule
